// ---- src/crf_adder.sv ----
// Adder and subtractor with half-carry, carry and overflow outputs.
`timescale 1ns/1ps
module crf_adder #(
  parameter int W  = 8,
  parameter int HB = 3
) (
  input  wire logic [W-1:0] a_i,     // first operand
  input  wire logic [W-1:0] b_i,     // second operand
  input  wire logic         cin_i,   // extra carry or borrow in
  input  wire logic         sub_i,   // subtract b from a
  output logic      [W-1:0] sum_o,   // result
  output logic              half_o,  // carry or borrow out of bit HB
  output logic              carry_o, // carry or borrow out of the top
  output logic              ovf_o    // signed overflow
);
  logic [W-1:0] bx;
  logic         ci;
  logic [HB+1:0] low;
  logic [W:0]   full;

  assign bx   = sub_i ? ~b_i : b_i;
  assign ci   = sub_i ? ~cin_i : cin_i;
  assign low  = {1'b0, a_i[HB:0]} + {1'b0, bx[HB:0]} + {{(HB+1){1'b0}}, ci};
  assign full = {1'b0, a_i} + {1'b0, bx} + {{W{1'b0}}, ci};
  assign sum_o   = full[W-1:0];
  assign half_o  = sub_i ? ~low[HB+1] : low[HB+1];
  assign carry_o = sub_i ? ~full[W] : full[W];
  assign ovf_o   = (a_i[W-1] == bx[W-1]) && (full[W-1] != a_i[W-1]);
endmodule

// ---- src/crf_core.sv ----
// Programmer-visible register state of an 8-bit CPU core.
`timescale 1ns/1ps
module crf_core (
  input  wire logic            ref_clk_i,            // system clock
  input  wire logic            rst_i,                // sync reset
  input  wire logic            req_valid_i,          // instruction request
  input  wire crf_pkg::crf_req_t req_i,              // instruction fields
  output logic                 req_ready_o,          // request taken
  input  wire crf_pkg::crf_ea_t  ea_i,               // address request
  output logic          [15:0] ea_o,                 // effective address
  input  wire logic      [3:0] rd_idx_i,             // read index
  output logic           [7:0] rd_byte_o,            // byte read data
  output logic          [15:0] rd_word_o,            // word read data
  output logic           [7:0] condition_flags_o,    // flag byte
  output logic          [15:0] next_instr_counter_o, // program counter
  output logic          [15:0] fetch_addr_o,         // even fetch address
  output logic          [15:0] stack_pointer_reg_o,  // stack pointer
  input  wire logic            fetch_next_i,         // word fetched
  input  wire logic            irq_i,                // maskable request
  output logic                 irq_accept_o,         // interrupt taken
  input  wire logic            wake_i,               // leave power-down
  output logic                 sleep_o,              // power-down state
  output logic          [15:0] mem_addr_o,           // memory address
  output logic                 mem_rd_o,             // memory read
  output logic                 mem_wr_o,             // memory write
  output logic          [15:0] mem_wdata_o,          // write data
  input  wire logic     [15:0] mem_rdata_i           // read data
);
  // ****************************************************************
  // Storage and state
  // ****************************************************************
  typedef enum logic [2:0] {
    CRF_ST_VEC, CRF_ST_WAIT, CRF_ST_LOAD, CRF_ST_RUN, CRF_ST_SLEEP
  } crf_state_t;

  crf_state_t  state_reg;
  logic [7:0]  upper_byte_regs [crf_pkg::CRF_NREG];
  logic [7:0]  lower_byte_regs [crf_pkg::CRF_NREG];
  logic [15:0] pc_reg;
  logic        mask_reg;
  logic [6:0]  flags_reg;
  logic [1:0]  cnt_reg;
  logic        pop_reg;
  logic [15:0] ea_reg;
  logic [7:0]  rd_byte_reg;
  logic [15:0] rd_word_reg;
  logic [15:0] mem_addr_reg;
  logic        mem_rd_reg;
  logic        mem_wr_reg;
  logic [15:0] mem_wdata_reg;

  // ****************************************************************
  // Request decode
  // ****************************************************************
  crf_pkg::crf_op_t op;
  wire acc     = req_valid_i && req_ready_o;
  assign op    = req_i.op;
  wire is_neg  = op == crf_pkg::CRF_OP_NEG;
  wire is_sub  = op == crf_pkg::CRF_OP_SUB || op == crf_pkg::CRF_OP_SUBX ||
                 op == crf_pkg::CRF_OP_CMP || is_neg;
  wire is_ext  = op == crf_pkg::CRF_OP_ADDX || op == crf_pkg::CRF_OP_SUBX;
  wire is_arit = op == crf_pkg::CRF_OP_ADD || is_ext || is_sub;
  wire is_mov  = op == crf_pkg::CRF_OP_MOV;
  wire is_flg  = op == crf_pkg::CRF_OP_LDC || op == crf_pkg::CRF_OP_AND_FLAGS_INSTR ||
                 op == crf_pkg::CRF_OP_ORC || op == crf_pkg::CRF_OP_XOR_FLAGS_INSTR;
  wire is_push = op == crf_pkg::CRF_OP_CALL || op == crf_pkg::CRF_OP_EXC;
  wire use_w   = req_i.wide && !is_ext && !is_neg;
  wire exc_acc = acc && op == crf_pkg::CRF_OP_EXC;

  // ****************************************************************
  // Operand selection
  // ****************************************************************
  wire [2:0]  dp = req_i.dst[2:0];
  wire [2:0]  sp_i = req_i.src[2:0];
  wire [15:0] a_w = {upper_byte_regs[dp], lower_byte_regs[dp]};
  wire [15:0] s_w = {upper_byte_regs[sp_i], lower_byte_regs[sp_i]};
  wire [7:0]  a_b = req_i.dst[3] ? lower_byte_regs[dp] : upper_byte_regs[dp];
  wire [7:0]  s_b = req_i.src[3] ? lower_byte_regs[sp_i] :
                    upper_byte_regs[sp_i];
  wire [15:0] b_w = req_i.use_imm ? req_i.imm : s_w;
  wire [7:0]  b_b = req_i.use_imm ? req_i.imm[7:0] : s_b;
  wire [7:0]  ad_a = is_neg ? 8'h00 : a_b;
  wire [7:0]  ad_b = is_neg ? a_b : b_b;
  wire        cin  = is_ext && flags_reg[crf_pkg::CRF_FLG_C];
  wire [7:0]  sum_b;
  wire [15:0] sum_w;
  wire        h_b, c_b, v_b, h_w, c_w, v_w;

  crf_adder #(.W(8), .HB(crf_pkg::CRF_HB_BYTE)) u_add_b (
    .a_i(ad_a), .b_i(ad_b), .cin_i(cin), .sub_i(is_sub),
    .sum_o(sum_b), .half_o(h_b), .carry_o(c_b), .ovf_o(v_b)
  );
  crf_adder #(.W(16), .HB(crf_pkg::CRF_HB_WORD)) u_add_w (
    .a_i(a_w), .b_i(b_w), .cin_i(1'b0), .sub_i(is_sub),
    .sum_o(sum_w), .half_o(h_w), .carry_o(c_w), .ovf_o(v_w)
  );

  wire [15:0] res_w = is_mov ? b_w : sum_w;
  wire [7:0]  res_b = is_mov ? b_b : sum_b;
  wire        res_n = use_w ? res_w[15] : res_b[7];
  wire        res_z = use_w ? (res_w == 16'h0000) : (res_b == 8'h00);

  // ****************************************************************
  // Flag register
  // ****************************************************************
  wire [7:0] flg_cur = {mask_reg, flags_reg};
  wire [7:0] flg_op  = op == crf_pkg::CRF_OP_LDC  ? b_b :
                       op == crf_pkg::CRF_OP_AND_FLAGS_INSTR ? (flg_cur & b_b) :
                       op == crf_pkg::CRF_OP_ORC  ? (flg_cur | b_b) :
                       (flg_cur ^ b_b);
  wire flg_wr = acc && is_flg;
  wire ari_wr = acc && is_arit;
  wire mov_wr = acc && is_mov;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mask_reg <= 1'b1;
    end else if (exc_acc) begin
      mask_reg <= 1'b1;
    end else if (flg_wr) begin
      mask_reg <= flg_op[crf_pkg::CRF_FLG_I];
    end
  end

  // The low seven flag bits have no reset and start unknown.
  always_ff @(posedge ref_clk_i) begin
    if (flg_wr) begin
      flags_reg <= flg_op[6:0];
    end else if (ari_wr) begin
      flags_reg[crf_pkg::CRF_FLG_H] <= use_w ? h_w : h_b;
      flags_reg[crf_pkg::CRF_FLG_N] <= res_n;
      flags_reg[crf_pkg::CRF_FLG_Z] <= res_z;
      flags_reg[crf_pkg::CRF_FLG_V] <= use_w ? v_w : v_b;
      flags_reg[crf_pkg::CRF_FLG_C] <= use_w ? c_w : c_b;
    end else if (mov_wr) begin
      flags_reg[crf_pkg::CRF_FLG_N] <= res_n;
      flags_reg[crf_pkg::CRF_FLG_Z] <= res_z;
      flags_reg[crf_pkg::CRF_FLG_V] <= 1'b0;
    end
  end

  // ****************************************************************
  // Effective address
  // ****************************************************************
  wire [2:0]  ei   = ea_i.reg_idx;
  wire [15:0] base = {upper_byte_regs[ei], lower_byte_regs[ei]};
  wire [15:0] step = ea_i.wide ? crf_pkg::CRF_WORD_STEP :
                     crf_pkg::CRF_BYTE_STEP;
  wire [15:0] dec  = base - step;
  wire [15:0] inc  = base + step;
  logic [15:0] ea_raw;
  always_comb begin
    case (ea_i.mode)
      crf_pkg::CRF_AM_REG:   ea_raw = base;
      crf_pkg::CRF_AM_IND:   ea_raw = base;
      crf_pkg::CRF_AM_DISP:  ea_raw = base + ea_i.disp;
      crf_pkg::CRF_AM_INC:   ea_raw = base;
      crf_pkg::CRF_AM_DEC:   ea_raw = dec;
      crf_pkg::CRF_AM_ABS:   ea_raw = ea_i.disp;
      crf_pkg::CRF_AM_IMM:   ea_raw = ea_i.disp;
      crf_pkg::CRF_AM_PCREL: ea_raw = pc_reg + ea_i.disp;
      crf_pkg::CRF_AM_MIND:  ea_raw = {8'h00, ea_i.disp[7:0]};
      default:               ea_raw = base;
    endcase
  end
  wire mem_mode = ea_i.mode != crf_pkg::CRF_AM_REG &&
                  ea_i.mode != crf_pkg::CRF_AM_IMM;
  // Word operands never straddle an odd address.
  wire [15:0] ea_fix = (ea_i.wide && mem_mode) ? {ea_raw[15:1], 1'b0} :
                       ea_raw;
  wire ea_wr = ea_i.step && (ea_i.mode == crf_pkg::CRF_AM_INC ||
                             ea_i.mode == crf_pkg::CRF_AM_DEC);
  wire [15:0] ea_upd = ea_i.mode == crf_pkg::CRF_AM_INC ? inc : dec;

  // ****************************************************************
  // General registers
  // ****************************************************************
  wire [15:0] sp_w = {upper_byte_regs[crf_pkg::CRF_SP_IDX],
                      lower_byte_regs[crf_pkg::CRF_SP_IDX]};
  wire [15:0] sp_dn = sp_w - crf_pkg::CRF_WORD_STEP;
  wire [15:0] sp_up = sp_w + crf_pkg::CRF_WORD_STEP;
  wire reg_wr  = acc && (is_mov || (is_arit && op != crf_pkg::CRF_OP_CMP));
  wire sp_wr   = (acc && is_push) || (state_reg == CRF_ST_LOAD && pop_reg);
  wire [15:0] sp_next = (acc && is_push) ? sp_dn : sp_up;

  // Data registers hold no reset value.
  always_ff @(posedge ref_clk_i) begin
    for (int i = 0; i < crf_pkg::CRF_NREG; i++) begin
      if (reg_wr && use_w && dp == 3'(i)) begin
        {upper_byte_regs[i], lower_byte_regs[i]} <= res_w;
      end else if (reg_wr && !use_w && dp == 3'(i)) begin
        if (req_i.dst[3]) begin
          lower_byte_regs[i] <= res_b;
        end else begin
          upper_byte_regs[i] <= res_b;
        end
      end else if (sp_wr && crf_pkg::CRF_SP_IDX == 3'(i)) begin
        {upper_byte_regs[i], lower_byte_regs[i]} <= sp_next;
      end else if (ea_wr && ei == 3'(i)) begin
        {upper_byte_regs[i], lower_byte_regs[i]} <= ea_upd;
      end
    end
  end

  wire [2:0]  ri = rd_idx_i[2:0];
  always_ff @(posedge ref_clk_i) begin
    rd_word_reg <= {upper_byte_regs[ri], lower_byte_regs[ri]};
    rd_byte_reg <= rd_idx_i[3] ? lower_byte_regs[ri] : upper_byte_regs[ri];
    ea_reg      <= ea_fix;
  end

  // ****************************************************************
  // Sequencer, program counter and memory port
  // ****************************************************************
  wire pc_jump = acc && (op == crf_pkg::CRF_OP_JMP || is_push);
  wire run     = state_reg == CRF_ST_RUN;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_reg     <= CRF_ST_VEC;
      pc_reg        <= crf_pkg::CRF_VEC_RESET;
      cnt_reg       <= 2'h0;
      pop_reg       <= 1'b0;
      mem_addr_reg  <= crf_pkg::CRF_VEC_RESET;
      mem_rd_reg    <= 1'b0;
      mem_wr_reg    <= 1'b0;
      mem_wdata_reg <= 16'h0000;
    end else begin
      mem_wr_reg <= 1'b0;
      cnt_reg    <= acc ? crf_pkg::CRF_EXEC_WAIT :
                    (cnt_reg != 2'h0 ? cnt_reg - 2'h1 : 2'h0);
      case (state_reg)
        CRF_ST_VEC: begin
          mem_addr_reg <= crf_pkg::CRF_VEC_RESET;
          mem_rd_reg   <= 1'b1;
          pop_reg      <= 1'b0;
          state_reg    <= CRF_ST_WAIT;
        end
        CRF_ST_WAIT: begin
          mem_rd_reg <= 1'b0;
          state_reg  <= CRF_ST_LOAD;
        end
        CRF_ST_LOAD: begin
          pc_reg    <= mem_rdata_i;
          pop_reg   <= 1'b0;
          state_reg <= CRF_ST_RUN;
        end
        CRF_ST_RUN: begin
          if (pc_jump) begin
            pc_reg <= req_i.imm;
          end else if (fetch_next_i) begin
            pc_reg <= pc_reg + crf_pkg::CRF_WORD_STEP;
          end
          if (acc && is_push) begin
            mem_addr_reg  <= sp_dn;
            mem_wdata_reg <= pc_reg;
            mem_wr_reg    <= 1'b1;
          end
          if (acc && op == crf_pkg::CRF_OP_RET) begin
            mem_addr_reg <= sp_w;
            mem_rd_reg   <= 1'b1;
            pop_reg      <= 1'b1;
            state_reg    <= CRF_ST_WAIT;
          end else if (acc && op == crf_pkg::CRF_OP_SLEEP) begin
            state_reg <= CRF_ST_SLEEP;
          end
        end
        CRF_ST_SLEEP: begin
          if (wake_i || irq_accept_o) begin
            state_reg <= CRF_ST_RUN;
          end
        end
        default: state_reg <= CRF_ST_VEC;
      endcase
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign req_ready_o          = run && cnt_reg == 2'h0;
  assign irq_accept_o         = irq_i && !mask_reg &&
                                (run || state_reg == CRF_ST_SLEEP);
  assign condition_flags_o    = flg_cur;
  assign next_instr_counter_o = pc_reg;
  assign fetch_addr_o         = {pc_reg[15:1], 1'b0};
  assign stack_pointer_reg_o  = sp_w;
  assign sleep_o              = state_reg == CRF_ST_SLEEP;
  assign ea_o                 = ea_reg;
  assign rd_byte_o            = rd_byte_reg;
  assign rd_word_o            = rd_word_reg;
  assign mem_addr_o           = mem_addr_reg;
  assign mem_rd_o             = mem_rd_reg;
  assign mem_wr_o             = mem_wr_reg;
  assign mem_wdata_o          = mem_wdata_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  wire [4:0]  hb_ref = {1'b0, a_b[3:0]} + {1'b0, b_b[3:0]};
  wire [12:0] hw_ref = {1'b0, a_w[11:0]} + {1'b0, b_w[11:0]};
  wire add_b = acc && op == crf_pkg::CRF_OP_ADD && !req_i.wide;
  wire add_w = acc && op == crf_pkg::CRF_OP_ADD && req_i.wide;

  reset_mask_a: assert property (@(posedge ref_clk_i)
    $fell(rst_i) |-> condition_flags_o[7])
    else $error("mask bit not set after reset");
  exc_mask_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    exc_acc |=> condition_flags_o[7])
    else $error("exception did not set mask bit");
  irq_gate_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    condition_flags_o[7] |-> !irq_accept_o)
    else $error("interrupt taken while masked");
  fetch_even_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    fetch_addr_o[0] == 1'b0 && fetch_addr_o[15:1] == pc_reg[15:1])
    else $error("fetch address not even");
  half_byte_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    add_b |=> condition_flags_o[5] == $past(hb_ref[4]))
    else $error("byte half carry wrong");
  half_word_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    add_w |=> condition_flags_o[5] == $past(hw_ref[12]))
    else $error("word half carry wrong");
  instr_states_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    acc && op != crf_pkg::CRF_OP_RET && op != crf_pkg::CRF_OP_SLEEP
    |=> !req_ready_o ##1 req_ready_o)
    else $error("instruction not two states");
  sp_push_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    acc && is_push |=> stack_pointer_reg_o == $past(sp_dn) &&
    mem_wr_o && mem_addr_o == stack_pointer_reg_o)
    else $error("push did not move stack pointer");
  vector_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $fell(rst_i) |-> ##1 mem_rd_o && mem_addr_o == 16'h0000 ##2
    next_instr_counter_o == $past(mem_rdata_i))
    else $error("reset vector not loaded");
  sleep_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    acc && op == crf_pkg::CRF_OP_SLEEP |=> sleep_o)
    else $error("sleep did not power down");
  ea_word_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ea_i.mode == crf_pkg::CRF_AM_DISP && !ea_i.wide
    |=> ea_o == $past(base + ea_i.disp))
    else $error("address not from full pair");

  exc_c: cover property (@(posedge ref_clk_i) exc_acc);
  ret_c: cover property (@(posedge ref_clk_i)
    acc && op == crf_pkg::CRF_OP_RET ##4 req_ready_o);
  wake_c: cover property (@(posedge ref_clk_i) sleep_o ##1 !sleep_o);
  irq_c: cover property (@(posedge ref_clk_i) irq_accept_o);
endmodule

// ---- src/crf_pkg.sv ----
// Shared constants and types for the CPU register file and flags.
package crf_pkg;
  localparam int          CRF_NREG       = 8;
  localparam logic [2:0]  CRF_SP_IDX     = 3'h7;
  localparam int          CRF_FLG_I      = 7;
  localparam int          CRF_FLG_U      = 6;
  localparam int          CRF_FLG_H      = 5;
  localparam int          CRF_FLG_N      = 3;
  localparam int          CRF_FLG_Z      = 2;
  localparam int          CRF_FLG_V      = 1;
  localparam int          CRF_FLG_C      = 0;
  localparam int          CRF_HB_BYTE    = 3;
  localparam int          CRF_HB_WORD    = 11;
  localparam logic [15:0] CRF_VEC_RESET  = 16'h0000;
  localparam logic [15:0] CRF_WORD_STEP  = 16'h0002;
  localparam logic [15:0] CRF_BYTE_STEP  = 16'h0001;
  localparam logic [1:0]  CRF_EXEC_WAIT  = 2'h1;
  localparam logic [7:0]  CRF_MASK_ONLY  = 8'h80;

  typedef enum logic [4:0] {
    CRF_OP_NOP, CRF_OP_ADD, CRF_OP_ADDX, CRF_OP_SUB, CRF_OP_SUBX,
    CRF_OP_CMP, CRF_OP_NEG, CRF_OP_MOV, CRF_OP_LDC, CRF_OP_AND_FLAGS_INSTR,
    CRF_OP_ORC, CRF_OP_XOR_FLAGS_INSTR, CRF_OP_JMP, CRF_OP_EXC, CRF_OP_CALL,
    CRF_OP_RET, CRF_OP_SLEEP
  } crf_op_t;

  typedef enum logic [3:0] {
    CRF_AM_REG, CRF_AM_IND, CRF_AM_DISP, CRF_AM_INC, CRF_AM_DEC,
    CRF_AM_ABS, CRF_AM_IMM, CRF_AM_PCREL, CRF_AM_MIND
  } crf_mode_t;

  // Byte index: bit 3 set selects the lower byte, bits 2:0 the pair.
  typedef struct packed {
    crf_op_t     op;
    logic        wide;
    logic [3:0]  dst;
    logic [3:0]  src;
    logic        use_imm;
    logic [15:0] imm;
  } crf_req_t;

  typedef struct packed {
    crf_mode_t   mode;
    logic        wide;
    logic [2:0]  reg_idx;
    logic [15:0] disp;
    logic        step;
  } crf_ea_t;
endpackage

// ---- tb/crf_mem_model.sv ----
// Word-wide memory seen by the core, with a two-cycle read answer.
`timescale 1ns/1ps
module crf_mem_model #(
  parameter logic [15:0] VEC = 16'h0000
) (
  input  wire logic        ref_clk_i,   // system clock
  input  wire logic [15:0] mem_addr_i,  // address
  input  wire logic        mem_rd_i,    // read strobe
  input  wire logic        mem_wr_i,    // write strobe
  input  wire logic [15:0] mem_wdata_i, // write data
  output logic      [15:0] mem_rdata_o  // read data
);
  logic [15:0] mem [32768];
  logic [15:0] addr_q;
  logic        rd_q = 0;
  logic        tog = 0;
  initial mem[0] = VEC;
  always @(posedge ref_clk_i) begin
    rd_q <= mem_rd_i;
    tog <= ~tog;
    if (mem_rd_i) addr_q <= mem_addr_i;
    if (mem_wr_i) mem[mem_addr_i[15:1]] <= mem_wdata_i;
  end
  // Data is valid only in the cycle after the strobe falls.
  assign mem_rdata_o = (rd_q && !mem_rd_i) ? mem[addr_q[15:1]] : {16{tog}};
endmodule

// ---- tb/tb_crf_core.sv ----
// Self-checking bench for the CPU register file and flags.
`timescale 1ns/1ps
module tb_crf_core;
  localparam logic [15:0] VEC = 16'h0123;
  logic        ref_clk_i = 0, rst_i = 1, req_valid_i = 0, fetch_next_i = 0;
  logic        irq_i = 0, wake_i = 0, pend = 0, pend_q = 0;
  logic        req_ready_o, irq_accept_o, sleep_o, mem_rd_o, mem_wr_o, h, v;
  logic [3:0]  rd_idx_i = 0;
  logic [7:0]  rd_byte_o, condition_flags_o;
  logic [15:0] ea_o, rd_word_o, next_instr_counter_o, fetch_addr_o;
  logic [15:0] stack_pointer_reg_o, mem_addr_o, mem_wdata_o, mem_rdata_i;
  logic [15:0] a, b, x, y, s, mk, rw;
  logic [31:0] lfsr = 32'hd4b1;
  logic [19:0] q [$];
  logic [15:0] obs [11];
  int          err_count = 0, cmp_count = 0, cyc = 0, tb, lo;
  crf_pkg::crf_req_t req_i = '0;
  crf_pkg::crf_ea_t  ea_i = '0;
  crf_pkg::crf_op_t  op;
  string       nm [11] = '{"word", "byte", "flags", "hv", "mask", "pc",
                           "fetch", "sp", "irq", "sleep", "ea"};

  crf_core i_dut (.ref_clk_i, .rst_i, .req_valid_i, .req_i, .req_ready_o,
    .ea_i, .ea_o, .rd_idx_i, .rd_byte_o, .rd_word_o, .condition_flags_o,
    .next_instr_counter_o, .fetch_addr_o, .stack_pointer_reg_o,
    .fetch_next_i, .irq_i, .irq_accept_o, .wake_i, .sleep_o, .mem_addr_o,
    .mem_rd_o, .mem_wr_o, .mem_wdata_o, .mem_rdata_i);
  crf_mem_model #(.VEC(VEC)) i_mem (.ref_clk_i(ref_clk_i),
    .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o),
    .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));

  always #2.5 ref_clk_i = ~ref_clk_i;
  always_comb obs = '{rd_word_o, {8'h0, rd_byte_o}, {8'h0, condition_flags_o},
    {14'h0, condition_flags_o[5], condition_flags_o[1]},
    {15'h0, condition_flags_o[7]}, next_instr_counter_o, fetch_addr_o,
    stack_pointer_reg_o, {15'h0, irq_accept_o}, {15'h0, sleep_o}, ea_o};

  function automatic logic [31:0] nxt(input logic [31:0] r);
    return {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
  endfunction

  task automatic cmp(input logic [3:0] k, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s exp %h got %h", nm[k], e, g);
    end
  endtask

  task end_of_test;
    $display("compares %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Notes an expectation; the monitor compares it at the falling edge after the next rising edge.
  task chk(input logic [3:0] k, input logic [15:0] e, input logic [3:0] i = 0);
    rd_idx_i <= i;
    q.push_back({k, e});
    pend <= 1;
    @(posedge ref_clk_i) pend <= 0;
    @(posedge ref_clk_i);
  endtask

  task ins(input crf_pkg::crf_op_t o, input logic w, input logic [3:0] d,
           input logic [15:0] im);
    req_i <= '{o, w, d, 4'h0, 1'b1, im};
    req_valid_i <= 1;
    do @(negedge ref_clk_i); while (req_ready_o !== 1'b1);
    @(posedge ref_clk_i) req_valid_i <= 0;
    @(posedge ref_clk_i);
  endtask

  always @(posedge ref_clk_i) begin
    pend_q <= pend;
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      end_of_test();
    end
  end
  always @(negedge ref_clk_i) begin
    if (pend_q) begin
      cmp(q[0][19:16], q[0][15:0], obs[q[0][19:16]]);
      void'(q.pop_front());
    end
  end

  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 0;
    repeat (6) @(posedge ref_clk_i);
    chk(5, VEC);
    chk(6, VEC & 16'hfffe);
    chk(4, 16'h1);
    fetch_next_i <= 1;
    @(posedge ref_clk_i) fetch_next_i <= 0;
    chk(5, VEC + 16'h2);
    ins(crf_pkg::CRF_OP_LDC, 0, 0, 16'h7f);
    chk(2, 16'h7f);
    ins(crf_pkg::CRF_OP_AND_FLAGS_INSTR, 0, 0, 16'h40);
    chk(2, 16'h40);
    ins(crf_pkg::CRF_OP_ORC, 0, 0, 16'h10);
    chk(2, 16'h50);
    ins(crf_pkg::CRF_OP_XOR_FLAGS_INSTR, 0, 0, 16'h50);
    irq_i <= 1;
    chk(8, 16'h1);
    ins(crf_pkg::CRF_OP_MOV, 1, 7, 16'h0400);
    ins(crf_pkg::CRF_OP_EXC, 0, 0, 16'h0200);
    chk(4, 16'h1);
    chk(8, 16'h0);
    chk(7, 16'h03fe);
    irq_i <= 0;
    ins(crf_pkg::CRF_OP_RET, 0, 0, 16'h0);
    ins(crf_pkg::CRF_OP_NOP, 0, 0, 16'h0);
    chk(5, VEC + 16'h2);
    chk(7, 16'h0400);
    rw = 16'hbe00;
    ins(crf_pkg::CRF_OP_MOV, 1, 1, rw);
    for (int i = 0; i < 8; i++) begin
      op = i < 2 ? crf_pkg::CRF_OP_ADD : i < 4 ? crf_pkg::CRF_OP_SUB :
           i < 6 ? crf_pkg::CRF_OP_CMP : crf_pkg::CRF_OP_NEG;
      mk = (i[0] && op != crf_pkg::CRF_OP_NEG) ? 16'hffff : 16'h00ff;
      lfsr = nxt(lfsr);
      a = lfsr[15:0] & mk;
      lfsr = nxt(lfsr);
      b = lfsr[15:0] & mk;
      ins(crf_pkg::CRF_OP_MOV, mk[8], mk[8] ? 4'h1 : 4'h9, a);
      rw = mk[8] ? a : {rw[15:8], a[7:0]};
      ins(op, mk[8], mk[8] ? 4'h1 : 4'h9, b);
      x = op == crf_pkg::CRF_OP_NEG ? 16'h0 : a;
      y = op == crf_pkg::CRF_OP_NEG ? a : b;
      s = (op == crf_pkg::CRF_OP_ADD ? x + y : x - y) & mk;
      tb = mk[8] ? 15 : 7;
      lo = mk[8] ? 4096 : 16;
      h = op == crf_pkg::CRF_OP_ADD ? (x % lo + y % lo >= lo) :
          (x % lo < y % lo);
      v = ((x[tb] ^ y[tb]) == (op != crf_pkg::CRF_OP_ADD)) && (s[tb] != x[tb]);
      if (op != crf_pkg::CRF_OP_CMP) rw = mk[8] ? s : {rw[15:8], s[7:0]};
      chk(3, {14'h0, h, v});
      chk(0, rw, 4'h1);
    end
    ea_i <= '{crf_pkg::CRF_AM_IND, 1'b0, 3'h1, 16'h0011, 1'b0};
    chk(10, rw);
    ea_i <= '{crf_pkg::CRF_AM_DISP, 1'b0, 3'h1, 16'h0011, 1'b0};
    chk(10, rw + 16'h0011);
    ins(crf_pkg::CRF_OP_JMP, 0, 0, 16'h0300);
    chk(5, 16'h0300);
    ea_i <= '{crf_pkg::CRF_AM_PCREL, 1'b0, 3'h1, 16'h0010, 1'b0};
    chk(10, 16'h0310);
    ea_i <= '{crf_pkg::CRF_AM_ABS, 1'b1, 3'h1, 16'h0013, 1'b0};
    chk(10, 16'h0012);
    ins(crf_pkg::CRF_OP_CALL, 0, 0, 16'h0500);
    chk(7, 16'h03fe);
    chk(5, 16'h0500);
    ins(crf_pkg::CRF_OP_RET, 0, 0, 16'h0);
    ins(crf_pkg::CRF_OP_NOP, 0, 0, 16'h0);
    chk(5, 16'h0300);
    ins(crf_pkg::CRF_OP_LDC, 0, 0, 16'h01);
    ins(crf_pkg::CRF_OP_MOV, 0, 9, 16'h000f);
    ins(crf_pkg::CRF_OP_ADDX, 0, 9, 16'h0000);
    chk(3, 16'h0002);
    chk(1, 16'h0010, 4'h9);
    ins(crf_pkg::CRF_OP_SLEEP, 0, 0, 16'h0);
    chk(9, 16'h1);
    wake_i <= 1;
    @(posedge ref_clk_i) wake_i <= 0;
    chk(9, 16'h0);
    end_of_test();
  end
endmodule
